// *** tmc_pkg.sv ***
/*
  tmc_pkg: register indices, byte addresses, field positions, reset
  values and cycle counts for the 8-bit timer/counter with its shared
  prescaler.
  Assumes a 32-bit APB slave where each register takes one aligned
  word. The byte address of a register is four times its index.
*/
package tmc_pkg;

  // register indices, as printed, and their byte addresses
  localparam logic [7:0]  IDX_COUNT_VALUE   = 8'h01;
  localparam logic [7:0]  IDX_INT_CONTROL   = 8'h0B;
  localparam logic [7:0]  IDX_OPTION_CONFIG = 8'h81;
  localparam logic [7:0]  IDX_PORT_A_DIR    = 8'h85;
  localparam logic [7:0]  IDX_IRQ_STATUS    = 8'h90;
  localparam logic [7:0]  IDX_IRQ_CLEAR     = 8'h91;
  localparam logic [7:0]  IDX_IRQ_ENABLE    = 8'h92;

  localparam int          ADDR_W = 12;
  localparam logic [11:0] ADDR_COUNT_VALUE   = {2'h0, IDX_COUNT_VALUE, 2'h0};
  localparam logic [11:0] ADDR_INT_CONTROL   = {2'h0, IDX_INT_CONTROL, 2'h0};
  localparam logic [11:0] ADDR_OPTION_CONFIG = {2'h0, IDX_OPTION_CONFIG,
                                                2'h0};
  localparam logic [11:0] ADDR_PORT_A_DIR    = {2'h0, IDX_PORT_A_DIR, 2'h0};
  localparam logic [11:0] ADDR_IRQ_STATUS    = {2'h0, IDX_IRQ_STATUS, 2'h0};
  localparam logic [11:0] ADDR_IRQ_CLEAR     = {2'h0, IDX_IRQ_CLEAR, 2'h0};
  localparam logic [11:0] ADDR_IRQ_ENABLE    = {2'h0, IDX_IRQ_ENABLE, 2'h0};

  // option_config fields
  localparam int          CLK_SRC_BIT   = 5;
  localparam int          EDGE_SEL_BIT  = 4;
  localparam int          PSA_BIT       = 3;
  localparam int          RATIO_LSB     = 0;
  localparam int          RATIO_W       = 3;

  // interrupt_control fields
  localparam int          OVF_FLAG_BIT  = 2;
  localparam int          OVF_IE_BIT    = 5;

  // sticky status / enable / clear layout
  localparam int          IRQ_W         = 2;
  localparam int          IRQ_OVF_BIT   = 0;
  localparam int          IRQ_WDT_BIT   = 1;

  // values after reset
  localparam logic [7:0]  RST_COUNT_VALUE   = 8'h00;
  localparam logic [7:0]  RST_INT_CONTROL   = 8'h00;
  localparam logic [7:0]  RST_OPTION_CONFIG = 8'hFF;
  localparam logic [7:0]  RST_PORT_A_DIR    = 8'hFF;
  localparam logic [1:0]  RST_IRQ           = 2'h0;

  // counts
  localparam logic [7:0]  COUNT_ALL_ONES    = 8'hFF;
  localparam logic [1:0]  INHIBIT_INSTR     = 2'h2;  // instruction cycles
  localparam int          INSTR_DIV_DEF     = 4;     // pclk per instruction

endpackage

// *** tmc_timer.sv ***
/*
  tmc_timer: 8-bit timer/counter with a shared 8-bit prescaler that
  serves either the counter or the watchdog postscaler, an overflow
  flag with mask, and a sticky status/enable/clear interrupt group,
  all behind an APB slave.
  Assumes sleep_mode, watchdog_clear_instr and watchdog_osc_tick come
  from logic on pclk; external_count_input is an asynchronous pin.
*/
`timescale 1ns/10ps

// What this block does
// - clock select zero counts instruction cycles
// - count write blocks counting two instruction cycles
// - clock select one counts pin, edge selectable
// - count pin synchronised before counting
// - one prescaler, counter or watchdog, exclusive
// - prescaler value never readable nor loadable
// - assign zero: counter ratios 1:2 to 1:256
// - assign one: watchdog ratios 1:1 to 1:128
// - count write clears prescaler when counter-assigned
// - watchdog clear clears prescaler when watchdog-assigned
// - assignment may change any time, nothing halts
// - wrap FFh to 00h sets overflow flag
// - overflow request only when enable bit set
// - counter stops during sleep
module tmc_timer
#(
  parameter int INSTR_DIV = tmc_pkg::INSTR_DIV_DEF  // pclk per instruction
)
(
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [tmc_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic                       external_count_input,
  input  wire logic                       sleep_mode,
  input  wire logic                       watchdog_clear_instr,
  input  wire logic                       watchdog_osc_tick,
  output logic                            watchdog_post_tick,
  output logic                            overflow_irq,
  output logic                            irq
);
  import tmc_pkg::*;

  // registers seen by software
  logic [7:0]       count_value_reg;        // the counter itself
  logic [7:0]       int_control_reg;        // flag, enable, other bits
  logic [7:0]       option_config_reg;      // source, edge, assign, ratio
  logic [7:0]       port_a_dir_reg;         // stored direction bits
  logic [IRQ_W-1:0] irq_status_reg;         // sticky events
  logic [IRQ_W-1:0] irq_enable_reg;         // event mask

  // hidden prescaler and timing state
  logic [7:0]       presc_reg;              // shared prescaler count
  logic [1:0]       inhib_reg;              // instruction cycles left
  logic [7:0]       icyc_reg;               // pclk within instruction
  logic             ext_s1_reg;             // pin sync, first stage
  logic             ext_s2_reg;             // pin sync, second stage
  logic             ext_s3_reg;             // previous synced level

  // apb answer flops and registered outputs
  logic [31:0]      prdata_reg;
  logic             pready_reg;
  logic             pslverr_reg;
  logic             wdt_post_reg;
  logic             ovf_irq_reg;
  logic             irq_reg;
  // decoded fields
  logic             clock_source_select;
  logic             count_edge_select;
  logic             prescaler_assign;
  logic [2:0]       prescale_ratio;

  assign clock_source_select = option_config_reg[CLK_SRC_BIT];
  assign count_edge_select   = option_config_reg[EDGE_SEL_BIT];
  assign prescaler_assign    = option_config_reg[PSA_BIT];
  assign prescale_ratio      = option_config_reg[RATIO_LSB +: RATIO_W];
  // mask of prescaler bits that must be all ones for one output tick
  function automatic logic [7:0] ratio_mask(input logic [3:0] log2n);
    logic [8:0] one_hot;
    one_hot    = 9'h001 << log2n;
    ratio_mask = 8'(one_hot - 9'h001);
  endfunction

  // apb strobes: a transfer completes where pready is seen high
  logic       apb_done;
  logic       apb_wr;
  logic       cnt_wr;       // software writes the count
  logic       ictl_wr;      // software writes interrupt_control
  logic [7:0] wbyte;        // low byte of write data
  assign apb_done = psel & penable & pready_reg;
  assign apb_wr   = apb_done & pwrite;
  assign cnt_wr   = apb_wr & (paddr == ADDR_COUNT_VALUE);
  assign ictl_wr  = apb_wr & (paddr == ADDR_INT_CONTROL);
  assign wbyte    = pwdata[7:0];

  // instruction cycle strobe, one pclk in INSTR_DIV
  logic instr_stb;
  assign instr_stb = (icyc_reg == 8'(INSTR_DIV - 1));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      icyc_reg <= 8'h00;
    else if (instr_stb)
      icyc_reg <= 8'h00;
    else
      icyc_reg <= icyc_reg + 8'h01;
  end

  // two-flop pin synchroniser plus a history flop for edge finding
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ext_s1_reg <= 1'b0;
      ext_s2_reg <= 1'b0;
      ext_s3_reg <= 1'b0;
    end
    else
    begin
      ext_s1_reg <= external_count_input;
      ext_s2_reg <= ext_s1_reg;
      ext_s3_reg <= ext_s2_reg;
    end
  end

  // chosen edge of the synchronised pin
  logic ext_edge;
  assign ext_edge = count_edge_select ? (ext_s3_reg & ~ext_s2_reg)
                                      : (~ext_s3_reg & ext_s2_reg);

  // source tick: instruction cycle or pin edge, none while asleep
  logic src_tick;
  logic allowed;
  assign src_tick = ~sleep_mode &
                    (clock_source_select ? ext_edge
                                         : instr_stb);
  assign allowed  = src_tick & (inhib_reg == 2'h0);

  // counter tick after optional prescaling
  logic [7:0] cnt_mask;
  logic [7:0] wdt_mask;
  logic       cnt_tick;
  logic       wdt_hit;
  assign cnt_mask = ratio_mask({1'b0, prescale_ratio} + 4'h1);
  assign wdt_mask = ratio_mask({1'b0, prescale_ratio});
  // counter-assigned: every 2^(ratio+1) ticks; else every tick
  assign cnt_tick = allowed &
                    (prescaler_assign |
                     ((presc_reg & cnt_mask) == cnt_mask));
  assign wdt_hit  = watchdog_osc_tick &
                    ((presc_reg & wdt_mask) == wdt_mask);

  // inhibit window after a count write, in instruction cycles
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      inhib_reg <= 2'h0;
    else if (cnt_wr)
      inhib_reg <= INHIBIT_INSTR;
    else if (instr_stb && inhib_reg != 2'h0)
      inhib_reg <= inhib_reg - 2'h1;
  end

  // the single prescaler, owned by one side at a time; switching the
  // owner does not clear or stop it, so neither side halts
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      presc_reg <= 8'h00;
    else if (!prescaler_assign)
    begin
      if (cnt_wr)
        presc_reg <= 8'h00;
      else if (allowed)
        presc_reg <= presc_reg + 8'h01;
    end
    else
    begin
      if (watchdog_clear_instr)
        presc_reg <= 8'h00;
      else if (watchdog_osc_tick)
        presc_reg <= presc_reg + 8'h01;
    end
  end

  // watchdog postscaler output, one pulse per selected ratio
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wdt_post_reg <= 1'b0;
    else
      wdt_post_reg <= prescaler_assign & wdt_hit &
                      ~watchdog_clear_instr;
  end

  // the count: software write wins over an increment
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count_value_reg <= RST_COUNT_VALUE;
    else if (cnt_wr)
      count_value_reg <= wbyte;
    else if (cnt_tick)
      count_value_reg <= count_value_reg + 8'h01;
  end

  // overflow on the wrap from all ones
  logic ovf_evt;
  assign ovf_evt = cnt_tick & ~cnt_wr &
                   (count_value_reg == COUNT_ALL_ONES);

  // interrupt_control: overflow set wins over a software clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      int_control_reg <= RST_INT_CONTROL;
    else
    begin
      if (ictl_wr)
        int_control_reg <= wbyte;
      if (ovf_evt)
        int_control_reg[OVF_FLAG_BIT] <= 1'b1;
    end
  end

  // option and port direction registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      option_config_reg <= RST_OPTION_CONFIG;
      port_a_dir_reg    <= RST_PORT_A_DIR;
    end
    else if (apb_wr)
    begin
      // owner change takes effect at once
      if (paddr == ADDR_OPTION_CONFIG)
        option_config_reg <= wbyte;
      else if (paddr == ADDR_PORT_A_DIR)
        port_a_dir_reg <= wbyte;
    end
  end

  // sticky status, enable, write-one-to-clear; set wins over clear
  logic [IRQ_W-1:0] irq_evt;
  logic [IRQ_W-1:0] irq_clr;
  assign irq_evt[IRQ_OVF_BIT] = ovf_evt;
  assign irq_evt[IRQ_WDT_BIT] = prescaler_assign & wdt_hit &
                                ~watchdog_clear_instr;
  assign irq_clr = (apb_wr && paddr == ADDR_IRQ_CLEAR) ?
                   pwdata[IRQ_W-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_status_reg <= RST_IRQ;
    else
      irq_status_reg <= (irq_status_reg & ~irq_clr) | irq_evt;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_enable_reg <= RST_IRQ;
    else if (apb_wr && paddr == ADDR_IRQ_ENABLE)
      irq_enable_reg <= pwdata[IRQ_W-1:0];
  end

  // interrupt outputs, registered
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ovf_irq_reg <= 1'b0;
      irq_reg     <= 1'b0;
    end
    else
    begin
      ovf_irq_reg <= int_control_reg[OVF_FLAG_BIT] &
                     int_control_reg[OVF_IE_BIT];
      irq_reg     <= |(irq_status_reg & irq_enable_reg);
    end
  end

  // read mux; the prescaler has no address
  logic [31:0] rd_mux;
  logic        rd_hit;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    if (paddr == ADDR_COUNT_VALUE)
      rd_mux[7:0] = count_value_reg;
    else if (paddr == ADDR_INT_CONTROL)
      rd_mux[7:0] = int_control_reg;
    else if (paddr == ADDR_OPTION_CONFIG)
      rd_mux[7:0] = option_config_reg;
    else if (paddr == ADDR_PORT_A_DIR)
      rd_mux[7:0] = port_a_dir_reg;
    else if (paddr == ADDR_IRQ_STATUS)
      rd_mux[IRQ_W-1:0] = irq_status_reg;
    else if (paddr == ADDR_IRQ_CLEAR)
      rd_mux = 32'h0000_0000;                          // write-only
    else if (paddr == ADDR_IRQ_ENABLE)
      rd_mux[IRQ_W-1:0] = irq_enable_reg;
    else
      rd_hit = 1'b0;
  end

  // apb slave: ready one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end
    else if (psel && penable && !pready_reg)
    begin
      pready_reg  <= 1'b1;
      pslverr_reg <= ~rd_hit;
      prdata_reg  <= pwrite ? 32'h0000_0000 : rd_mux;
    end
    else
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end
  end

  assign prdata             = prdata_reg;
  assign pready             = pready_reg;
  assign pslverr            = pslverr_reg;
  assign watchdog_post_tick = wdt_post_reg;
  assign overflow_irq       = ovf_irq_reg;
  assign irq                = irq_reg;

  // checks next to the logic
  a_inhibit_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (inhib_reg != 2'h0 && !cnt_wr) |=>
      count_value_reg == $past(count_value_reg))
    else $error("count moved inside write inhibit");
  a_timer_step: assert property (@(posedge pclk) disable iff (!presetn)
    (!clock_source_select && prescaler_assign && instr_stb &&
     !sleep_mode && inhib_reg == 2'h0 && !cnt_wr) |=>
      count_value_reg == $past(count_value_reg) + 8'h01)
    else $error("timer mode did not step");
  a_pin_edge: assert property (@(posedge pclk) disable iff (!presetn)
    (clock_source_select && prescaler_assign && !sleep_mode &&
     inhib_reg == 2'h0 && !cnt_wr && ext_edge) |=>
      count_value_reg == $past(count_value_reg) + 8'h01)
    else $error("pin edge not counted");
  // a pin edge must not reach the count before it has been synchronised
  a_sync_edge: assert property (@(posedge pclk) disable iff (!presetn)
    ($rose(external_count_input) && clock_source_select &&
     !count_edge_select && !cnt_wr) |=> $stable(count_value_reg))
    else $error("pin edge counted before sync");
  a_presc_ratio: assert property (@(posedge pclk) disable iff (!presetn)
    (cnt_tick && !prescaler_assign) |->
      (presc_reg & cnt_mask) == cnt_mask)
    else $error("counter ticked off ratio");
  a_wdt_ratio: assert property (@(posedge pclk) disable iff (!presetn)
    (prescaler_assign && wdt_hit && !watchdog_clear_instr) |=>
      watchdog_post_tick ##1 (!watchdog_post_tick || $past(wdt_hit)))
    else $error("watchdog postscale pulse wrong");
  a_cnt_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (cnt_wr && !prescaler_assign) |=> presc_reg == 8'h00)
    else $error("count write kept prescaler");
  a_wdt_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (watchdog_clear_instr && prescaler_assign) |=>
      presc_reg == 8'h00)
    else $error("watchdog clear kept prescaler");
  a_ovf_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (cnt_tick && !cnt_wr && count_value_reg == COUNT_ALL_ONES) |=>
      int_control_reg[OVF_FLAG_BIT] && count_value_reg == 8'h00)
    else $error("wrap did not set flag");
  a_ovf_mask: assert property (@(posedge pclk) disable iff (!presetn)
    overflow_irq |-> $past(int_control_reg[OVF_IE_BIT]) &&
      $past(int_control_reg[OVF_FLAG_BIT]))
    else $error("overflow request while masked");
  a_sleep_stop: assert property (@(posedge pclk) disable iff (!presetn)
    (sleep_mode && !cnt_wr) |=>
      count_value_reg == $past(count_value_reg))
    else $error("counter ran in sleep");

endmodule

// *** tmc_pin_src.sv ***
/*
  tmc_pin_src: behavioural source for the external count pin.
  Assumes the bench sets idle level, pulse count and half period, then
  raises go for one clock; the pin is free of the bench clock.
*/
`timescale 1ns/10ps

module tmc_pin_src
(
  input  wire logic        go,          // start a burst on rising edge
  input  wire logic        idle_level,  // level held between bursts
  input  wire logic [7:0]  pulses,      // number of pulses in a burst
  input  wire logic [15:0] half_ns,     // half period, prompt or slow
  output logic             pin          // drives the count pin
);
  logic busy;  // high while a burst runs

  initial
  begin
    pin  = 1'b0;
    busy = 1'b0;
  end

  // idle level follows the bench only outside bursts
  always @(idle_level)
    if (!busy)
      pin = idle_level;

  // each pulse leaves idle and comes back, so edges come in pairs
  always @(posedge go)
  begin
    busy = 1'b1;
    repeat (pulses)
    begin
      #(half_ns) pin = ~idle_level;
      #(half_ns) pin = idle_level;
    end
    busy = 1'b0;
  end
endmodule

// *** tmc_timer_bench.sv ***
/*
  tmc_timer_bench: self-checking bench for the timer/counter.
  Assumes INSTR_DIV of 4 and the register map of tmc_pkg; one test
  task for each feature, an APB master task for every access.
*/
`timescale 1ns/10ps

module tmc_timer_bench;
  import tmc_pkg::*;
  localparam int LIMIT = 40000;  // cycle ceiling for the whole run

  logic              pclk, presetn, psel, penable, pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, rd, a;
  logic              pready, pslverr, serr, pin, sleep_mode;
  logic              wd_clr, wd_tick, post_tick, overflow_irq, irq;
  logic              src_go, src_idle;
  logic [7:0]        src_n;
  logic [15:0]       src_half;
  int                fail_count, cmp_count, cyc, post_cnt;

  tmc_timer #(.INSTR_DIV(4)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .external_count_input(pin),
    .sleep_mode(sleep_mode), .watchdog_clear_instr(wd_clr),
    .watchdog_osc_tick(wd_tick), .watchdog_post_tick(post_tick),
    .overflow_irq(overflow_irq), .irq(irq));

  tmc_pin_src src_u (.go(src_go), .idle_level(src_idle),
    .pulses(src_n), .half_ns(src_half), .pin(pin));

  // clock of 8 ns
  always #4 pclk = ~pclk;

  // counts postscaled watchdog ticks
  always @(posedge pclk)
    if (post_tick === 1'b1)
      post_cnt <= post_cnt + 1;

  // cuts a hang short
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      fail_count++;
      end_sim();
    end
  end

  task automatic end_sim;
    $display("compares=%0d mismatches=%0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // compare one value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // compare against an inclusive window
  task automatic rng(input logic [31:0] got, input logic [31:0] lo,
                     input logic [31:0] hi);
    cmp_count++;
    if ($isunknown(got) || got < lo || got > hi)
    begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask

  // one APB transfer, held until pready is seen; only the run's cycle
  // ceiling ends a wait that never gets its answer
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] ad,
                     input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    chk(32'(n), 32'h2);  // answer in the second access cycle
    rd   = prdata;
    serr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] ad, input logic [31:0] wd);
    apb(1'b1, ad, wd);
  endtask

  task automatic rdchk(input logic [ADDR_W-1:0] ad, input logic [31:0] e);
    apb(1'b0, ad, 32'h0);
    chk(rd, e);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // count read, kept in rd
  task automatic rdc;
    apb(1'b0, ADDR_COUNT_VALUE, 32'h0);
  endtask

  // difference of two count reads, modulo 256
  task automatic dchk(input logic [31:0] x, input logic [31:0] y,
                      input logic [7:0] d);
    chk({24'h0, y[7:0] - x[7:0]}, {24'h0, d});
  endtask

  task automatic wd_pulse(input int n);
    repeat (n)
    begin
      @(posedge pclk);
      wd_tick <= 1'b1;
      @(posedge pclk);
      wd_tick <= 1'b0;
    end
  endtask

  task automatic clr_pulse;
    @(posedge pclk);
    wd_clr <= 1'b1;
    @(posedge pclk);
    wd_clr <= 1'b0;
  endtask

  // reset values, storage and an unmapped place
  task automatic t_reset;
    rdchk(ADDR_COUNT_VALUE, 32'h00);
    rdchk(ADDR_INT_CONTROL, 32'h00);
    rdchk(ADDR_OPTION_CONFIG, 32'hFF);
    rdchk(ADDR_PORT_A_DIR, 32'hFF);
    rdchk(ADDR_IRQ_STATUS, 32'h0);
    rdchk(ADDR_IRQ_ENABLE, 32'h0);
    wr(ADDR_PORT_A_DIR, 32'h5A);
    rdchk(ADDR_PORT_A_DIR, 32'h5A);
    apb(1'b0, 12'hFF0, 32'h0);
    chk({31'h0, serr}, 32'h1);
    chk(rd, 32'h0);
    $display("test reset done");
  endtask

  // timer mode: count write pause, steady rate, sleep
  task automatic t_timer;
    wr(ADDR_OPTION_CONFIG, 32'h08);
    wr(ADDR_COUNT_VALUE, 32'h10);
    idle(36);
    rdc();
    rng(rd, 32'h17, 32'h18);
    a = rd;
    idle(36);
    rdc();
    dchk(a, rd, 8'h0A);
    @(posedge pclk);
    sleep_mode <= 1'b1;
    idle(4);
    rdc();
    a = rd;
    idle(96);
    rdc();
    dchk(a, rd, 8'h00);
    sleep_mode <= 1'b0;
    $display("test timer done");
  endtask

  // counter-owned prescaler, every ratio, cleared by count write
  task automatic t_prescale;
    for (int r = 0; r < 8; r++)
    begin
      wr(ADDR_OPTION_CONFIG, 32'(r));
      wr(ADDR_COUNT_VALUE, 32'h0);
      idle(12);
      rdc();
      a = rd;
      idle((16 << r) - 4);
      rdc();
      dchk(a, rd, 8'h02);
    end
    wr(ADDR_COUNT_VALUE, 32'h0);
    idle(600);
    wr(ADDR_COUNT_VALUE, 32'h40);
    idle(996);
    rdchk(ADDR_COUNT_VALUE, 32'h40);
    $display("test prescale done");
  endtask

  // watchdog-owned prescaler, every ratio, cleared by clear pulse
  task automatic t_watchdog;
    int p0;
    clr_pulse();
    for (int r = 0; r < 8; r++)
    begin
      wr(ADDR_OPTION_CONFIG, 32'h08 | 32'(r));
      clr_pulse();
      p0 = post_cnt;
      wd_pulse(2 << r);
      idle(3);
      chk(32'(post_cnt - p0), 32'h2);
      if (r > 0)
      begin
        p0 = post_cnt;
        wd_pulse((1 << r) - 1);
        clr_pulse();
        wd_pulse((1 << r) - 1);
        idle(3);
        chk(32'(post_cnt - p0), 32'h0);
      end
    end
    $display("test watchdog done");
  endtask

  // one pin level change, then the count step it should cause
  task automatic pin_lvl(input logic lv, input logic [7:0] d);
    rdc();
    a = rd;
    @(posedge pclk);
    src_idle <= lv;
    idle(10);
    rdc();
    dchk(a, rd, d);
  endtask

  task automatic burst(input logic [7:0] n, input logic [15:0] h);
    rdc();
    a = rd;
    @(posedge pclk);
    src_n    <= n;
    src_half <= h;
    src_go   <= 1'b1;
    @(posedge pclk);
    src_go <= 1'b0;
    idle(int'(n) * int'(h) / 4 + 12);
    rdc();
    dchk(a, rd, n);
  endtask

  // pin counting on each edge, prompt and slow source
  task automatic t_pin;
    wr(ADDR_OPTION_CONFIG, 32'h28);
    pin_lvl(1'b1, 8'h01);
    pin_lvl(1'b0, 8'h00);
    burst(8'h05, 16'd20);
    wr(ADDR_OPTION_CONFIG, 32'h38);
    pin_lvl(1'b1, 8'h00);
    pin_lvl(1'b0, 8'h01);
    burst(8'h03, 16'd100);
    $display("test pin done");
  endtask

  // overflow flag, its mask, the status group and the irq line
  task automatic t_overflow;
    wr(ADDR_OPTION_CONFIG, 32'h08);
    wr(ADDR_INT_CONTROL, 32'h00);
    wr(ADDR_IRQ_CLEAR, 32'h3);
    wr(ADDR_COUNT_VALUE, 32'hFE);
    idle(40);
    sleep_mode <= 1'b1;
    idle(4);
    rdchk(ADDR_INT_CONTROL, 32'h04);
    rdchk(ADDR_IRQ_STATUS, 32'h1);
    chk({31'h0, overflow_irq}, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(ADDR_INT_CONTROL, 32'h24);
    idle(2);
    chk({31'h0, overflow_irq}, 32'h1);
    wr(ADDR_IRQ_ENABLE, 32'h1);
    idle(2);
    chk({31'h0, irq}, 32'h1);
    wr(ADDR_INT_CONTROL, 32'h04);
    idle(2);
    chk({31'h0, overflow_irq}, 32'h0);
    idle(50);
    rdchk(ADDR_INT_CONTROL, 32'h04);
    wr(ADDR_INT_CONTROL, 32'h00);
    rdchk(ADDR_INT_CONTROL, 32'h00);
    wr(ADDR_IRQ_CLEAR, 32'h1);
    idle(2);
    chk({31'h0, irq}, 32'h0);
    rdchk(ADDR_IRQ_STATUS, 32'h0);
    sleep_mode <= 1'b0;
    $display("test overflow done");
  endtask

  // main sequence
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    sleep_mode = 1'b0;
    wd_clr = 1'b0;
    wd_tick = 1'b0;
    src_go = 1'b0;
    src_idle = 1'b0;
    src_n = 8'h00;
    src_half = 16'h0000;
    fail_count = 0;
    cmp_count = 0;
    cyc = 0;
    post_cnt = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_timer();
    t_prescale();
    t_watchdog();
    t_pin();
    t_overflow();
    end_sim();
  end
endmodule
